// ### stpc_regs.vh
// stepper pin-control constants: offsets, field positions, reset values, timing counts
// assumes a 100 MHz pclk and an APB master with 32-bit data
`ifndef STPC_REGS_VH
`define STPC_REGS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define STPC_OFF_CTRL    12'h000
`define STPC_OFF_STATUS  12'h004
`define STPC_OFF_FAULT   12'h008
`define STPC_OFF_CURDAC  12'h00c
// ----------------------------------------
// ctrl fields
// ----------------------------------------
`define STPC_CTRL_BLANK_LSB  0
`define STPC_CTRL_BLANK_MSB  7
`define STPC_CTRL_RST        32'h0000_0032
// ----------------------------------------
// fault injection fields (overcurrent a, b, high side, overtemp)
// ----------------------------------------
`define STPC_FLT_OCA  0
`define STPC_FLT_OCB  1
`define STPC_FLT_OCH  2
`define STPC_FLT_OT   3
// ----------------------------------------
// counts
// ----------------------------------------
`define STPC_DAC_FULL     4'hf
`define STPC_ERR_TRIP     2'h3
`define STPC_OFF_CYCLES   6'h3f
`define STPC_OK_CYCLES    6'h3f
`endif

// ### stpc_pin_ctrl.v
// stand-alone pin control of a dual full-bridge stepper driver, with an apb status port
// assumes pins arrive asynchronous to pclk; the pwm oscillator clock arrives as a pin
//
// Summary of operation
// - low serial select gives stand-alone, serial off
// - stand-alone forces both current dac codes to 1111
// - bridge a mixed decay when its pin low
// - bridge b mixed decay when its pin low
// - bridge a polarity pin selects current direction
// - bridge b polarity pin selects current direction
// - fault high on latched overcurrent error or overtemperature
// - fault output always driven in stand-alone
// - standby high turns off all bridge drive and low-side outputs
// - standby high clears every latched error
// - bridges start on opposite oscillator edges
// - three overcurrents latch error, 63 cycles off
`timescale 1ns/10ps
`include "stpc_regs.vh"
module stpc_pin_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        serial_port_select,
	input  wire        bridge_a_mixdecay_n,
	input  wire        bridge_b_mixdecay_n,
	input  wire        bridge_a_polarity,
	input  wire        bridge_b_polarity,
	input  wire        standby_pin,
	input  wire        osc_clk_pin,
	input  wire [1:0]  sense_trip,
	input  wire        high_side_trip,
	input  wire        overtemp,
	output reg         fault_out,
	output reg         fault_oe,
	output reg         serial_enable,
	output reg  [3:0]  bridge_a_dac,
	output reg  [3:0]  bridge_b_dac,
	output reg  [1:0]  bridge_a_drive,
	output reg  [1:0]  bridge_b_drive,
	output reg  [1:0]  bridge_mixdecay,
	output reg  [1:0]  bridge_low_side
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam NS = 11;
	reg  [NS-1:0] sync1_q;
	reg  [NS-1:0] sync2_q;
	wire [NS-1:0] pins_raw;

	assign pins_raw = {overtemp, high_side_trip, sense_trip, osc_clk_pin, standby_pin,
		bridge_b_polarity, bridge_a_polarity, bridge_b_mixdecay_n,
		bridge_a_mixdecay_n, serial_port_select};

	// two flops per pin; only the second stage is read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= {NS{1'b0}};
			sync2_q <= {NS{1'b0}};
		end else begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
		end
	end

	wire       s_sps   = sync2_q[0];
	wire [1:0] s_mdn   = sync2_q[2:1];
	wire [1:0] s_pol   = sync2_q[4:3];
	wire       s_stby  = sync2_q[5];
	wire       s_osc   = sync2_q[6];
	wire [1:0] s_sense = sync2_q[8:7];
	wire       s_hs    = sync2_q[9];
	wire       s_ot    = sync2_q[10];
	wire       alone   = ~s_sps;

	// ----------------------------------------
	// apb registers
	// ----------------------------------------
	reg  [31:0] ctrl_q;
	reg  [3:0]  finj_q;
	reg         osc_q;
	reg  [1:0]  err_lat_q;
	wire [7:0]  blank_len = ctrl_q[`STPC_CTRL_BLANK_MSB:`STPC_CTRL_BLANK_LSB];
	wire        acc       = psel & penable;
	wire        wr        = acc & pwrite;

	// zero wait states; unmapped addresses answer with pslverr
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= `STPC_CTRL_RST;
			finj_q  <= 4'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				case (paddr)
				`STPC_OFF_CTRL: begin
					prdata <= ctrl_q;
				end
				`STPC_OFF_STATUS: begin
					// latched errors sit above the live pin levels
					prdata <= {23'h000000,
						err_lat_q,   // [8:7] latched error b, a
						s_stby,      // [6] standby
						s_pol,       // [5:4] polarity b, a
						s_mdn,       // [3:2] decay select b, a
						alone,       // [1] stand-alone
						fault_out};  // [0] fault pin
				end
				`STPC_OFF_FAULT: begin
					prdata <= {28'h0000000, finj_q};
				end
				`STPC_OFF_CURDAC: begin
					prdata <= {24'h000000, bridge_b_dac, bridge_a_dac};
				end
				default: begin
					prdata  <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
				endcase
			end
			if (wr & pready) begin
				if (paddr == `STPC_OFF_CTRL)
					ctrl_q <= pwdata;
				if (paddr == `STPC_OFF_FAULT)
					finj_q <= pwdata[3:0];
			end
		end
	end

	// ----------------------------------------
	// oscillator edges, one per bridge
	// ----------------------------------------
	wire osc_rise = s_osc & ~osc_q;
	wire osc_fall = ~s_osc & osc_q;
	wire [1:0] cyc_start = {osc_fall, osc_rise};

	// ----------------------------------------
	// per bridge chopper and overcurrent counters
	// ----------------------------------------
	reg  [1:0] on_q;
	reg  [7:0] blank_q [0:1];
	reg  [1:0] cnt_q   [0:1];
	reg  [5:0] off_q   [0:1];
	reg  [5:0] ok_q    [0:1];
	reg  [1:0] pol_q;
	wire [1:0] oc_ev;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : br
			wire oc_raw = (s_sense[g] | finj_q[g] | s_hs | finj_q[`STPC_FLT_OCH]);
			wire live   = on_q[g] & (blank_q[g] == 8'h00);
			assign oc_ev[g] = live & oc_raw;
			wire restart = cyc_start[g] | (s_pol[g] != pol_q[g]);

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					on_q[g]    <= 1'b0;
					blank_q[g] <= 8'h00;
					cnt_q[g]   <= 2'h0;
					off_q[g]   <= 6'h00;
					ok_q[g]    <= 6'h00;
					pol_q[g]   <= 1'b0;
				end else if (s_stby) begin
					on_q[g]  <= 1'b0;
					cnt_q[g] <= 2'h0;
					off_q[g] <= 6'h00;
					ok_q[g]  <= 6'h00;
					pol_q[g] <= s_pol[g];
				end else begin
					pol_q[g] <= s_pol[g];
					// count cycles off and clean cycles at each cycle start
					if (cyc_start[g]) begin
						if (off_q[g] != 6'h00)
							off_q[g] <= off_q[g] - 6'h01;
						if (ok_q[g] == `STPC_OK_CYCLES)
							cnt_q[g] <= 2'h0;
						else
							ok_q[g] <= ok_q[g] + 6'h01;
					end
					if (restart & (off_q[g] == 6'h00) & ~(s_ot | finj_q[`STPC_FLT_OT])) begin
						on_q[g]    <= 1'b1;
						blank_q[g] <= blank_len;
					end else if (oc_ev[g]) begin
						on_q[g] <= 1'b0;
						ok_q[g] <= 6'h00;
						if (cnt_q[g] == `STPC_ERR_TRIP - 2'h1) begin
							cnt_q[g] <= `STPC_ERR_TRIP;
							off_q[g] <= `STPC_OFF_CYCLES;
						end else if (cnt_q[g] != `STPC_ERR_TRIP)
							cnt_q[g] <= cnt_q[g] + 2'h1;
					end else if (on_q[g] & s_sense[g] & (blank_q[g] == 8'h00)) begin
						on_q[g] <= 1'b0;
					end else if (s_ot | finj_q[`STPC_FLT_OT]) begin
						on_q[g] <= 1'b0;
					end
					if (blank_q[g] != 8'h00)
						blank_q[g] <= blank_q[g] - 8'h01;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// error latch, fault pin and bridge outputs
	// ----------------------------------------
	wire err_any = (cnt_q[0] == `STPC_ERR_TRIP) | (cnt_q[1] == `STPC_ERR_TRIP);
	wire ot_any  = s_ot | finj_q[`STPC_FLT_OT];

	// next values of the pin-side outputs; the flops below only register them
	reg  [1:0] err_lat_d;
	reg        fault_d;
	reg  [3:0] dac_d;
	reg  [1:0] drive_a_d;
	reg  [1:0] drive_b_d;
	reg  [1:0] mixdecay_d;
	reg  [1:0] low_side_d;

	// standby clears the latch and holds it clear while the pin stays high
	always @* begin
		err_lat_d = 2'b00;
		if (!s_stby) begin
			err_lat_d[0] = (cnt_q[0] == `STPC_ERR_TRIP);
			err_lat_d[1] = (cnt_q[1] == `STPC_ERR_TRIP);
		end
	end

	// fault pin: overcurrent latch or overtemperature, forced low in standby
	always @* begin
		fault_d = 1'b0;
		if (alone & ~s_stby)
			fault_d = err_any | ot_any;
	end

	// current dacs sit at full scale whenever stand-alone is selected
	always @* begin
		if (alone)
			dac_d = `STPC_DAC_FULL;
		else
			dac_d = 4'h0;
	end

	// drive[0] pulls out_first high, drive[1] pulls out_second high;
	// polarity low sends current from the first output to the second
	always @* begin
		drive_a_d = 2'b00;
		drive_b_d = 2'b00;
		if (on_q[0])
			drive_a_d = s_pol[0] ? 2'b10 : 2'b01;
		if (on_q[1])
			drive_b_d = s_pol[1] ? 2'b10 : 2'b01;
	end

	// decay pins are active low; serial mode holds both mixed decay outputs low
	always @* begin
		mixdecay_d = 2'b00;
		if (alone)
			mixdecay_d = ~s_mdn;
	end

	// low sides carry the slow decay while a bridge is off; all off in standby
	always @* begin
		low_side_d = ~on_q;
		if (s_stby)
			low_side_d = 2'b00;
	end

	// every output leaves straight from a flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_q           <= 1'b0;
			err_lat_q       <= 2'b00;
			fault_out       <= 1'b0;
			fault_oe        <= 1'b0;
			serial_enable   <= 1'b0;
			bridge_a_dac    <= 4'h0;
			bridge_b_dac    <= 4'h0;
			bridge_a_drive  <= 2'h0;
			bridge_b_drive  <= 2'h0;
			bridge_mixdecay <= 2'h0;
			bridge_low_side <= 2'h0;
		end else begin
			osc_q           <= s_osc;
			err_lat_q       <= err_lat_d;
			fault_out       <= fault_d;
			fault_oe        <= alone;
			serial_enable   <= ~alone;
			bridge_a_dac    <= dac_d;
			bridge_b_dac    <= dac_d;
			bridge_a_drive  <= drive_a_d;
			bridge_b_drive  <= drive_b_d;
			bridge_mixdecay <= mixdecay_d;
			bridge_low_side <= low_side_d;
		end
	end

endmodule

// ### stpc_pin_ctrl_assertions.sv
// checker: bus timing and pin relations at the stepper pin control ports
// assumes bind onto stpc_pin_ctrl; pins steady six cycles cover the sync latency
`timescale 1ns/10ps
module stpc_chk (
	input wire       pclk,
	input wire       presetn,
	input wire       psel,
	input wire       penable,
	input wire       pready,
	input wire       serial_port_select,
	input wire       bridge_a_mixdecay_n,
	input wire       bridge_a_polarity,
	input wire       standby_pin,
	input wire       overtemp,
	input wire       fault_out,
	input wire       serial_enable,
	input wire [3:0] bridge_a_dac,
	input wire [3:0] bridge_b_dac,
	input wire [1:0] bridge_a_drive,
	input wire [1:0] bridge_b_drive,
	input wire [1:0] bridge_mixdecay
);
	wire sa = !serial_port_select && !standby_pin; // stand-alone and awake
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero-wait one-cycle ready, then pin relations after the sync flops
	property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready not one cycle after setup");
	property p_mode; serial_port_select [*6] |-> serial_enable && bridge_a_dac == 4'h0; endproperty
	a_mode: assert property (p_mode) else $error("serial mode wrong");
	property p_dac; !serial_port_select [*6] |-> {bridge_b_dac, bridge_a_dac} == 8'hff; endproperty
	a_dac: assert property (p_dac) else $error("dac not full scale");
	property p_mix; (sa && !bridge_a_mixdecay_n) [*6] |-> bridge_mixdecay[0]; endproperty
	a_mix: assert property (p_mix) else $error("mixed decay a off");
	property p_pol; (sa && !bridge_a_polarity) [*6] |-> bridge_a_drive != 2'b10; endproperty
	a_pol: assert property (p_pol) else $error("bridge a reversed");
	property p_ot; (sa && overtemp) [*6] |-> fault_out; endproperty
	a_ot: assert property (p_ot) else $error("overtemp not reported");
	property p_stby; standby_pin [*6] |-> {bridge_a_drive, bridge_b_drive} == 4'h0; endproperty
	a_stby: assert property (p_stby) else $error("bridge on in standby");
	property p_clr; standby_pin [*6] |-> !fault_out; endproperty
	a_clr: assert property (p_clr) else $error("fault kept in standby");
endmodule
bind stpc_pin_ctrl stpc_chk u_chk (.pclk, .presetn, .psel, .penable, .pready,
	.serial_port_select, .bridge_a_mixdecay_n, .bridge_a_polarity, .standby_pin, .overtemp,
	.fault_out, .serial_enable, .bridge_a_dac, .bridge_b_dac, .bridge_a_drive, .bridge_b_drive,
	.bridge_mixdecay);

// ### stpc_ctrl_model.sv
// motion controller model: drives stand-alone pins and the pwm oscillator clock
// assumes the bench gives wanted levels {select, decay a, decay b, pol a, pol b, standby}
`timescale 1ns/10ps
module stpc_ctrl_model (
	input  wire       pclk,
	input  wire [5:0] want,
	output reg        serial_port_select,
	output reg        bridge_a_mixdecay_n,
	output reg        bridge_b_mixdecay_n,
	output reg        bridge_a_polarity,
	output reg        bridge_b_polarity,
	output reg        standby_pin,
	output reg        osc_clk_pin
);
	// square wave just under 100 khz, never left floating
	initial osc_clk_pin = 1'b0;
	always #5003 osc_clk_pin = ~osc_clk_pin;
	// pins change after a pclk edge; decay levels invert when serial mode is chosen
	always @(posedge pclk) begin
		serial_port_select <= want[5];
		bridge_a_mixdecay_n <= want[4] ^ want[5];
		bridge_b_mixdecay_n <= want[3] ^ want[5];
		bridge_a_polarity <= want[2];
		bridge_b_polarity <= want[1];
		standby_pin <= want[0];
	end
endmodule

// ### tb_stepper_standalone_pin_control.sv
// testbench: apb register checks and stand-alone pin scenarios
// assumes the design, its checker and the controller model are compiled first
`timescale 1ns/10ps
`include "stpc_regs.vh"
module tb_stepper_standalone_pin_control;
	reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, overtemp = 0, err;
	reg  [11:0] paddr = 0;
	reg  [31:0] pwdata = 0, rd;
	reg  [5:0]  want = 6'h20;
	reg  [1:0]  sense_trip = 0;
	reg         high_side_trip = 0;
	wire [31:0] prdata;
	wire        pready, pslverr, serial_port_select, bridge_a_mixdecay_n, bridge_b_mixdecay_n;
	wire        bridge_a_polarity, bridge_b_polarity, standby_pin, osc_clk_pin, fault_out;
	wire        fault_oe, serial_enable;
	wire [3:0]  bridge_a_dac, bridge_b_dac;
	wire [1:0]  bridge_a_drive, bridge_b_drive, bridge_mixdecay, bridge_low_side;
	integer     n_fail = 0, checked = 0, cyc = 0, i;
	always #5 pclk = ~pclk;
	stpc_pin_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .serial_port_select, .bridge_a_mixdecay_n, .bridge_b_mixdecay_n,
		.bridge_a_polarity, .bridge_b_polarity, .standby_pin, .osc_clk_pin, .sense_trip,
		.high_side_trip, .overtemp, .fault_out, .fault_oe, .serial_enable, .bridge_a_dac,
		.bridge_b_dac, .bridge_a_drive, .bridge_b_drive, .bridge_mixdecay, .bridge_low_side);
	stpc_ctrl_model u_ctrl (.pclk, .want, .serial_port_select, .bridge_a_mixdecay_n,
		.bridge_b_mixdecay_n, .bridge_a_polarity, .bridge_b_polarity, .standby_pin,
		.osc_clk_pin);
	// compare seen against expected and count
	task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD %0s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	// one apb transfer; read data and error taken at the ready edge
	task apb(input wr, input [11:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			rd = prdata;
			err = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			finish_test;
		end
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		apb(0, `STPC_OFF_CTRL, 0);
		chk(rd, `STPC_CTRL_RST, "ctrl");
		apb(1, `STPC_OFF_CTRL, 32'h0000_0010);
		apb(0, `STPC_OFF_CTRL, 0);
		chk(rd, 32'h0000_0010, "ctrl");
		apb(0, 12'h010, 0);
		chk({rd[30:0], err}, 32'h1, "unmapped");
		$display("test registers done");
		// every decay pin combination in stand-alone; polarity a follows decay b, polarity b follows decay a
		for (i = 0; i < 4; i = i + 1) begin
			want <= {1'b0, i[0], i[1], i[1], i[0], 1'b0};
			repeat (1100) @(posedge pclk);
			chk(bridge_mixdecay, {~i[1], ~i[0]}, "mixdecay");
			chk(bridge_a_drive, i[1] ? 2'b10 : 2'b01, "drive a");
			chk(bridge_b_drive, i[0] ? 2'b10 : 2'b01, "drive b");
		end
		apb(0, `STPC_OFF_CURDAC, 0);
		chk(rd, 32'h0000_00ff, "curdac");
		chk({fault_oe, serial_enable}, 2'b10, "mode");
		$display("test pins done");
		overtemp <= 1;
		repeat (8) @(posedge pclk);
		chk(fault_out, 1, "overtemp");
		overtemp <= 0;
		sense_trip <= 2'b01;
		repeat (4000) @(posedge pclk);
		apb(0, `STPC_OFF_STATUS, 0);
		chk({rd[7], fault_out, bridge_a_drive}, 4'hc, "overcur");
		sense_trip <= 2'b00;
		want <= 6'b011111;
		repeat (8) @(posedge pclk);
		chk({fault_out, bridge_a_drive, bridge_b_drive, bridge_low_side}, 0, "standby");
		apb(0, `STPC_OFF_STATUS, 0);
		chk(rd[8:7], 0, "cleared");
		want <= 6'b011110;
		high_side_trip <= 1;
		repeat (4000) @(posedge pclk);
		apb(0, `STPC_OFF_STATUS, 0);
		chk({rd[8:7], fault_out}, 3'b111, "highside");
		$display("test faults done");
		finish_test;
	end
endmodule
